// [p7fs_pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none

// Decides what one pin does; an alternate output always beats the port latch.
module p7fs_pin_cell
    import p7fs_pkg::*;
(
    input  wire logic      dir_i,
    input  wire logic      latch_i,
    input  wire logic      alt_oe_i,
    input  wire logic      alt_out_i,
    input  wire logic      pull_grp_i,
    input  wire logic      port_ok_i,
    output p7fs_pin_s      pin_o
);

    always_comb begin
        pin_o.oe   = alt_oe_i | (dir_i & port_ok_i);
        pin_o.out  = alt_oe_i ? alt_out_i : latch_i;
        pin_o.pull = ~alt_oe_i & ~dir_i & pull_grp_i & port_ok_i;
    end

endmodule : p7fs_pin_cell

`default_nettype wire

// [p7fs_pkg.sv]
`default_nettype none

package p7fs_pkg;

    // ------------------------------------------------------------
    // Register map, word aligned byte addresses
    // ------------------------------------------------------------
    localparam int unsigned P7FS_AW       = 6;
    localparam int unsigned P7FS_NREG     = 10;
    localparam logic [5:0]  P7FS_OFF_DIR  = 6'h00;
    localparam logic [5:0]  P7FS_OFF_LAT  = 6'h04;
    localparam logic [5:0]  P7FS_OFF_PULL = 6'h08;
    localparam logic [5:0]  P7FS_OFF_TRG  = 6'h0C;
    localparam logic [5:0]  P7FS_OFF_T2M  = 6'h10;
    localparam logic [5:0]  P7FS_OFF_T1M  = 6'h14;
    localparam logic [5:0]  P7FS_OFF_UDF  = 6'h18;
    localparam logic [5:0]  P7FS_OFF_UCTL = 6'h1C;
    localparam logic [5:0]  P7FS_OFF_TPH  = 6'h20;
    localparam logic [5:0]  P7FS_OFF_STAT = 6'h24;
    localparam logic [7:0]  P7FS_RST_REG  = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned P7FS_BIT_PIN3     = 3;
    localparam int unsigned P7FS_BIT_PIN4     = 4;
    localparam int unsigned P7FS_BIT_PIN5     = 5;
    localparam int unsigned P7FS_BIT_PULL_HI  = 7;
    localparam int unsigned P7FS_BIT_PULL_LO  = 6;
    localparam int unsigned P7FS_BIT_TRG_T2H  = 3;
    localparam int unsigned P7FS_BIT_TRG_T2L  = 2;
    localparam int unsigned P7FS_BIT_TRG_T1H  = 1;
    localparam int unsigned P7FS_BIT_TRG_T1L  = 0;
    localparam int unsigned P7FS_BIT_MODE_GT  = 4;
    localparam int unsigned P7FS_BIT_MODE_PO  = 2;
    localparam int unsigned P7FS_BIT_UDF_T2TP = 5;
    localparam int unsigned P7FS_BIT_UC_DIS   = 4;
    localparam int unsigned P7FS_BIT_UC_SEL   = 2;
    localparam int unsigned P7FS_BIT_TPH_SEL  = 2;

    typedef struct packed {
        logic oe;
        logic out;
        logic pull;
    } p7fs_pin_s;

endpackage : p7fs_pkg

`default_nettype wire

// [p7fs_top.sv]
// Behaviour
// - timer-two input pin feeds gate, trigger, count source
// - trigger-select pair must be zero for inputs
// - plain input without pull-up when bits clear
// - pull-up on port input when group bit set
// - timer-two output pin gives up/down polarity input
// - same pin gives two-phase pulse input
// - pulse output only without two-phase, three-phase
`timescale 1ns/1ps
`default_nettype none

module p7fs_top
    import p7fs_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [P7FS_AW-1:0]  wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [2:0]          pin_in_i,
    output logic      [2:0]          pin_out_o,
    output logic      [2:0]          pin_oe_o,
    output logic      [2:0]          pin_pullup_o,
    input  wire logic                timer_two_pulse_i,
    input  wire logic                serial_request_to_send_out_i,
    input  wire logic                w_phase_i,
    input  wire logic                v_phase_i,
    output logic                     timer_two_input_o,
    output logic                     timer_two_count_en_o,
    output logic                     timer_two_gate_en_o,
    output logic                     timer_two_updown_o,
    output logic                     timer_two_updown_en_o,
    output logic                     timer_two_twophase_o,
    output logic                     timer_two_twophase_en_o,
    output logic                     timer_one_input_o,
    output logic                     timer_one_count_en_o,
    output logic                     timer_one_gate_en_o,
    output logic                     serial_clear_to_send_in_o,
    output logic                     serial_cts_en_o
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] regs [0:P7FS_NREG-2];
    // Status is kept apart from the writable file so that each store has a single driving process.
    logic [7:0] stat;
    logic [3:0] idx;
    logic       wr_hit;
    logic       rd_map;

    assign idx    = wb_adr_i[5:2];
    assign rd_map = (idx < 4'(P7FS_NREG));
    // Status is read-only; writes to it and to holes are acknowledged and dropped.
    assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0]
                  & (idx < 4'(P7FS_NREG - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < P7FS_NREG - 1; i++) begin
                regs[i] <= P7FS_RST_REG;
            end
        end else if (ce_i && wr_hit) begin
            regs[idx] <= wb_dat_i[7:0];
        end
    end

    // Status register mirrors pin levels in [5:3] and drive enables in [2:0].
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat <= P7FS_RST_REG;
        end else if (ce_i) begin
            stat <= {2'h0, pin_in_i, pin_oe_o};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= !rd_map                      ? 32'h0000_0000
                      : (idx == 4'(P7FS_NREG - 1)) ? {24'h00_0000, stat}
                      :                               {24'h00_0000, regs[idx]};
        end
    end

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    logic [2:0] dir;
    logic [2:0] lat;
    logic       tph;
    logic       t2_in_ok;
    logic       t2_gate_ok;
    logic       t2_pulse_on;
    logic       t2_updn_ok;
    logic       t2_twoph_ok;
    logic       t1_in_ok;
    logic       t1_gate_ok;
    logic       rts_on;
    logic       cts_ok;
    logic       t2_tp;
    logic       t2_po;

    assign dir   = regs[P7FS_OFF_DIR[5:2]][P7FS_BIT_PIN5:P7FS_BIT_PIN3];
    assign lat   = regs[P7FS_OFF_LAT[5:2]][P7FS_BIT_PIN5:P7FS_BIT_PIN3];
    assign tph   = regs[P7FS_OFF_TPH[5:2]][P7FS_BIT_TPH_SEL];
    assign t2_tp = regs[P7FS_OFF_UDF[5:2]][P7FS_BIT_UDF_T2TP];
    assign t2_po = regs[P7FS_OFF_T2M[5:2]][P7FS_BIT_MODE_PO];

    assign t2_in_ok    = ~dir[2] & ~regs[P7FS_OFF_TRG[5:2]][P7FS_BIT_TRG_T2H]
                       & ~regs[P7FS_OFF_TRG[5:2]][P7FS_BIT_TRG_T2L] & ~tph;
    assign t2_gate_ok  = t2_in_ok & regs[P7FS_OFF_T2M[5:2]][P7FS_BIT_MODE_GT];
    assign t2_pulse_on = t2_po & ~t2_tp & ~tph;
    assign t2_updn_ok  = ~dir[1] & regs[P7FS_OFF_T2M[5:2]][P7FS_BIT_MODE_GT]
                       & ~t2_po & ~t2_tp & ~tph;
    assign t2_twoph_ok = ~dir[1] & regs[P7FS_OFF_T2M[5:2]][P7FS_BIT_MODE_GT]
                       & ~t2_po & t2_tp & ~tph;
    assign t1_in_ok    = ~dir[0] & ~regs[P7FS_OFF_TRG[5:2]][P7FS_BIT_TRG_T1H]
                       & ~regs[P7FS_OFF_TRG[5:2]][P7FS_BIT_TRG_T1L] & ~tph;
    assign t1_gate_ok  = t1_in_ok & regs[P7FS_OFF_T1M[5:2]][P7FS_BIT_MODE_GT];
    assign rts_on      = ~regs[P7FS_OFF_UCTL[5:2]][P7FS_BIT_UC_DIS]
                       & regs[P7FS_OFF_UCTL[5:2]][P7FS_BIT_UC_SEL] & ~tph;
    assign cts_ok      = ~dir[0] & ~regs[P7FS_OFF_UCTL[5:2]][P7FS_BIT_UC_DIS]
                       & ~regs[P7FS_OFF_UCTL[5:2]][P7FS_BIT_UC_SEL] & ~tph;

    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Index 0 is port bit 3, index 2 is port bit 5.
    logic [2:0] alt_oe;
    logic [2:0] alt_out;
    logic [2:0] pull_grp;
    logic [2:0] port_ok;
    p7fs_pin_s  next_pin [0:2];

    assign alt_oe   = {tph, tph | t2_pulse_on, tph | rts_on};
    assign alt_out  = {w_phase_i,
                       tph ? w_phase_i : timer_two_pulse_i,
                       tph ? v_phase_i : serial_request_to_send_out_i};
    assign pull_grp = {regs[P7FS_OFF_PULL[5:2]][P7FS_BIT_PULL_HI],
                       regs[P7FS_OFF_PULL[5:2]][P7FS_BIT_PULL_HI],
                       regs[P7FS_OFF_PULL[5:2]][P7FS_BIT_PULL_LO]};
    // The timer-two output pin is no port while pulse or two-phase use owns it.
    assign port_ok  = {~tph, ~tph & ~t2_po & ~t2_tp, ~tph};

    for (genvar g = 0; g < 3; g++) begin : g_pin
        p7fs_pin_cell u_cell (
            .dir_i      (dir[g]),
            .latch_i    (lat[g]),
            .alt_oe_i   (alt_oe[g]),
            .alt_out_i  (alt_out[g]),
            .pull_grp_i (pull_grp[g]),
            .port_ok_i  (port_ok[g]),
            .pin_o      (next_pin[g])
        );

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pin_oe_o[g]     <= 1'b0;
                pin_out_o[g]    <= 1'b0;
                pin_pullup_o[g] <= 1'b0;
            end else if (ce_i) begin
                pin_oe_o[g]     <= next_pin[g].oe;
                pin_out_o[g]    <= next_pin[g].out;
                pin_pullup_o[g] <= next_pin[g].pull;
            end
        end
    end

    // ------------------------------------------------------------
    // Inputs handed to the peripherals
    // ------------------------------------------------------------
    // Disabled inputs read low so a peripheral never counts a floating pin.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_two_input_o       <= 1'b0;
            timer_two_count_en_o    <= 1'b0;
            timer_two_gate_en_o     <= 1'b0;
            timer_one_input_o       <= 1'b0;
            timer_one_count_en_o    <= 1'b0;
            timer_one_gate_en_o     <= 1'b0;
        end else if (ce_i) begin
            timer_two_input_o       <= t2_in_ok & pin_in_i[2];
            timer_two_count_en_o    <= t2_in_ok;
            timer_two_gate_en_o     <= t2_gate_ok;
            timer_one_input_o       <= t1_in_ok & pin_in_i[0];
            timer_one_count_en_o    <= t1_in_ok;
            timer_one_gate_en_o     <= t1_gate_ok;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_two_updown_o      <= 1'b0;
            timer_two_updown_en_o   <= 1'b0;
            timer_two_twophase_o    <= 1'b0;
            timer_two_twophase_en_o <= 1'b0;
            serial_clear_to_send_in_o <= 1'b0;
            serial_cts_en_o         <= 1'b0;
        end else if (ce_i) begin
            timer_two_updown_o      <= t2_updn_ok & pin_in_i[1];
            timer_two_updown_en_o   <= t2_updn_ok;
            timer_two_twophase_o    <= t2_twoph_ok & pin_in_i[1];
            timer_two_twophase_en_o <= t2_twoph_ok;
            serial_clear_to_send_in_o <= cts_ok & pin_in_i[0];
            serial_cts_en_o         <= cts_ok;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_t2_count;
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && ce_i && !dir[2] && !tph && regs[P7FS_OFF_TRG[5:2]][3:2] == 2'b00
        |=> timer_two_count_en_o && timer_two_input_o == $past(pin_in_i[2]);
    endproperty
    a_t2_count: assert property (p_t2_count) else $error("timer two input not routed");

    property p_t1_block;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && regs[P7FS_OFF_TRG[5:2]][1:0] != 2'b00 |=> !timer_one_count_en_o && !timer_one_gate_en_o;
    endproperty
    a_t1_block: assert property (p_t1_block) else $error("timer one input with trigger select set");

    property p_plain_in;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !dir[2] && !regs[P7FS_OFF_PULL[5:2]][7] && !tph |=> !pin_oe_o[2] && !pin_pullup_o[2];
    endproperty
    a_plain_in: assert property (p_plain_in) else $error("pin five not a plain input");

    property p_pull_lo;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !dir[0] && !tph && !rts_on |=> pin_pullup_o[0] == $past(regs[P7FS_OFF_PULL[5:2]][6]);
    endproperty
    a_pull_lo: assert property (p_pull_lo) else $error("lower group pull-up wrong");

    property p_updn;
        @(posedge clk_i) disable iff (rst_i)
        ce_i ##1 ce_i |-> timer_two_updown_en_o == $past(t2_updn_ok) && !(timer_two_updown_en_o && pin_oe_o[1]);
    endproperty
    a_updn: assert property (p_updn) else $error("polarity input selection wrong");

    property p_twoph_nopulse;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && t2_tp && !dir[1] |=> !pin_oe_o[1] || $past(tph);
    endproperty
    a_twoph_nopulse: assert property (p_twoph_nopulse) else $error("pin four driven in two-phase use");

    property p_pulse;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && t2_po && !t2_tp && !tph |=> pin_oe_o[1] && pin_out_o[1] == $past(timer_two_pulse_i);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse output not on pin four");

    property p_rts;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rts_on |=> pin_oe_o[0] && pin_out_o[0] == $past(serial_request_to_send_out_i) && !serial_cts_en_o;
    endproperty
    a_rts: assert property (p_rts) else $error("flow-control output not on pin three");

    property p_three_phase;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tph |=> pin_oe_o == 3'h7 && pin_out_o == {$past(w_phase_i), $past(w_phase_i), $past(v_phase_i)}
                        && pin_pullup_o == 3'h0;
    endproperty
    a_three_phase: assert property (p_three_phase) else $error("motor phases do not own the pins");

    property p_port_out;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && dir[2] && !tph |=> pin_oe_o[2] && pin_out_o[2] == $past(lat[2]);
    endproperty
    a_port_out: assert property (p_port_out) else $error("port latch not on pin five");

endmodule : p7fs_top

`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb
    import p7fs_pkg::*;
;
    logic               clk    = 1'b0;
    logic               rst    = 1'b1;
    logic               ce     = 1'b1;
    logic               cyc    = 1'b0;
    logic               stb    = 1'b0;
    logic               we     = 1'b0;
    logic [P7FS_AW-1:0] adr    = '0;
    logic [3:0]         sel    = 4'h0;
    logic [31:0]        dat_w  = 32'h0;
    logic [31:0]        dat_r;
    logic               ack;
    logic [2:0]         pin_in = 3'h0;
    logic [2:0]         pin_out;
    logic [2:0]         pin_oe;
    logic [2:0]         pin_pu;
    logic               pulse  = 1'b0;
    logic               rts    = 1'b0;
    logic               w_ph   = 1'b0;
    logic               v_ph   = 1'b0;
    logic               t2_in, t2_cnt, t2_gt, t2_ud, t2_ud_en, t2_tp, t2_tp_en;
    logic               t1_in, t1_cnt, t1_gt, cts, cts_en;
    logic [31:0]        q;
    int                 num_errors = 0;
    int                 compares   = 0;

    always #20 clk = ~clk;

    p7fs_top u_dut (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pin_pullup_o(pin_pu),
        .timer_two_pulse_i(pulse), .serial_request_to_send_out_i(rts), .w_phase_i(w_ph),
        .v_phase_i(v_ph), .timer_two_input_o(t2_in), .timer_two_count_en_o(t2_cnt),
        .timer_two_gate_en_o(t2_gt), .timer_two_updown_o(t2_ud), .timer_two_updown_en_o(t2_ud_en),
        .timer_two_twophase_o(t2_tp), .timer_two_twophase_en_o(t2_tp_en),
        .timer_one_input_o(t1_in), .timer_one_count_en_o(t1_cnt), .timer_one_gate_en_o(t1_gt),
        .serial_clear_to_send_in_o(cts), .serial_cts_en_o(cts_en)
    );

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One classic cycle; the release edge plus the next entry edge give the idle cycle.
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        chk("ack_idle", 32'h0, 32'(ack));
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        sel   <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h0, d}, 4'hF);
    endtask : wr

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic drive(input logic [2:0] p, input logic pl, input logic r, input logic w, input logic v);
        @(posedge clk);
        pin_in <= p; pulse <= pl; rts <= r; w_ph <= w; v_ph <= v;
    endtask : drive

    task automatic clr();
        for (int i = 0; i <= 32; i += 4) wr(i[5:0], 8'h00);
        settle();
    endtask : clr

    task automatic t_reset();
        settle();
        chk("oe", 32'h0, 32'(pin_oe));
        chk("pullup", 32'h0, 32'(pin_pu));
        chk("t2_cnt", 32'h1, 32'(t2_cnt));
        chk("t1_cnt", 32'h1, 32'(t1_cnt));
        chk("cts_en", 32'h1, 32'(cts_en));
        wb(1'b0, 6'h28, 32'h0, 4'hF);
        chk("unmapped", 32'h0, q);
        drive(3'h5, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(P7FS_OFF_STAT, 8'hFF);
        settle();
        wb(1'b0, P7FS_OFF_STAT, 32'h0, 4'hF);
        chk("stat", 32'h28, q);
        wb(1'b1, P7FS_OFF_DIR, 32'h38, 4'hE);
        settle();
        chk("oe_sel", 32'h0, 32'(pin_oe));
        $display("test reset done");
    endtask : t_reset

    task automatic t_timer();
        drive(3'h7, 1'b0, 1'b0, 1'b0, 1'b0);
        settle();
        chk("t2_in", 32'h1, 32'(t2_in));
        chk("t1_in", 32'h1, 32'(t1_in));
        chk("t2_gt0", 32'h0, 32'(t2_gt));
        @(posedge clk);
        ce     <= 1'b0;
        pin_in <= 3'h0;
        settle();
        chk("ce_hold", 32'h1, 32'(t2_in));
        @(posedge clk);
        ce <= 1'b1;
        settle();
        chk("ce_run", 32'h0, 32'(t2_in));
        drive(3'h7, 1'b0, 1'b0, 1'b0, 1'b0);
        settle();
        wr(P7FS_OFF_T2M, 8'h10);
        wr(P7FS_OFF_T1M, 8'h10);
        settle();
        chk("t2_gt", 32'h1, 32'(t2_gt));
        chk("t1_gt", 32'h1, 32'(t1_gt));
        for (int i = 0; i < 4; i++) begin
            wr(P7FS_OFF_TRG, 8'(1 << i));
            settle();
            chk("t2_cnt", 32'(i < 2), 32'(t2_cnt));
            chk("t1_cnt", 32'(i >= 2), 32'(t1_cnt));
            chk("t2_in", 32'(i < 2), 32'(t2_in));
        end
        wr(P7FS_OFF_TRG, 8'h00);
        wr(P7FS_OFF_DIR, 8'h20);
        wr(P7FS_OFF_TPH, 8'h04);
        settle();
        chk("t2_dir", 32'h0, 32'(t2_cnt));
        chk("t1_tph", 32'h0, 32'(t1_cnt));
        clr();
        $display("test timer inputs done");
    endtask : t_timer

    task automatic t_port();
        wr(P7FS_OFF_PULL, 8'hC0);
        settle();
        chk("pu_both", 32'h7, 32'(pin_pu));
        wr(P7FS_OFF_PULL, 8'h80);
        settle();
        chk("pu_hi", 32'h6, 32'(pin_pu));
        wr(P7FS_OFF_DIR, 8'h38);
        wr(P7FS_OFF_LAT, 8'h28);
        settle();
        chk("oe", 32'h7, 32'(pin_oe));
        chk("out", 32'h5, 32'(pin_out));
        chk("pu_drv", 32'h0, 32'(pin_pu));
        clr();
        chk("plain", 32'h0, {26'h0, pin_pu, pin_oe});
        $display("test port done");
    endtask : t_port

    task automatic t_timer_out();
        drive(3'h2, 1'b1, 1'b0, 1'b0, 1'b0);
        wr(P7FS_OFF_T2M, 8'h04);
        settle();
        chk("pulse_oe", 32'h2, 32'(pin_oe));
        chk("pulse_hi", 32'h1, 32'(pin_out[1]));
        drive(3'h2, 1'b0, 1'b0, 1'b0, 1'b0);
        settle();
        chk("pulse_lo", 32'h0, 32'(pin_out[1]));
        wr(P7FS_OFF_UDF, 8'h20);
        settle();
        chk("pulse_tp", 32'h0, 32'(pin_oe));
        wr(P7FS_OFF_T2M, 8'h10);
        wr(P7FS_OFF_UDF, 8'h00);
        settle();
        chk("ud", 32'h3, {30'h0, t2_ud_en, t2_ud});
        chk("tp_off", 32'h0, 32'(t2_tp_en));
        wr(P7FS_OFF_UDF, 8'h20);
        settle();
        chk("tp", 32'h3, {30'h0, t2_tp_en, t2_tp});
        chk("ud_off", 32'h0, 32'(t2_ud_en));
        wr(P7FS_OFF_DIR, 8'h10);
        settle();
        chk("tp_dir", 32'h0, 32'(t2_tp_en));
        clr();
        $display("test timer output pin done");
    endtask : t_timer_out

    task automatic t_flow();
        drive(3'h1, 1'b0, 1'b1, 1'b1, 1'b0);
        settle();
        chk("cts", 32'h3, {30'h0, cts_en, cts});
        wr(P7FS_OFF_UCTL, 8'h04);
        settle();
        chk("rts", 32'h3, {30'h0, pin_oe[0], pin_out[0]});
        chk("cts_rts", 32'h0, 32'(cts_en));
        wr(P7FS_OFF_UCTL, 8'h10);
        settle();
        chk("dis", 32'h0, {31'h0, pin_oe[0] | cts_en});
        wr(P7FS_OFF_UCTL, 8'h04);
        wr(P7FS_OFF_T2M, 8'h04);
        wr(P7FS_OFF_TPH, 8'h04);
        settle();
        chk("tph_oe", 32'h7, 32'(pin_oe));
        chk("tph_out", 32'h6, 32'(pin_out));
        drive(3'h1, 1'b1, 1'b0, 1'b0, 1'b1);
        settle();
        chk("tph_out2", 32'h1, 32'(pin_out));
        clr();
        $display("test flow and three-phase done");
    endtask : t_flow

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_timer();
        t_port();
        t_timer_out();
        t_flow();
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
